// File: core/adb_pkg.sv
// Behaviour
// - Outside emulation, fetching an undefined opcode or from 0000-007F raises an error.
// - 0000-001F core regs, 0020-007F peripheral regs, 0080-17FF RAM.
// - 1800-7FFF, C000-FDFF root; 8000-BFFF banked; FE00-FFFF either ROM.
// - Active-low output and write enables strobe external reads and writes.
// - Boot-ROM select bit routes top 512 bytes internally at 1; resets to 1.
// - Sleep bit set suppresses program chip select at address FFFF.
// - Two independent external chip selects are generated.
// - Emulation input builds internal buses from external pins.
// - Emulation low address byte follows data pins while strobe is high.
// - Read/not-write pin is output normally, input in emulation.
// - Data pins bidirectional normally, inputs in emulation.
// - Low eight address pins are always outputs.
// - Address pins 13..8 outputs normally, inputs in emulation.
// - Fetch begins in internal ROM after reset, then external code at 1800.
// - Program select covers all external space; bank bit may pick second.
package adb_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [2:0] ADB_OFS_SLEEP   = 3'h0;
    localparam logic [2:0] ADB_OFS_BOOT    = 3'h1;
    localparam logic [2:0] ADB_OFS_BANK    = 3'h2;
    localparam logic [2:0] ADB_OFS_STATUS  = 3'h3;
    localparam logic [2:0] ADB_OFS_CLEAR   = 3'h4;
    localparam logic [2:0] ADB_OFS_ENABLE  = 3'h5;
    localparam int         ADB_SLEEP_BIT   = 1;
    localparam int         ADB_BOOT_BIT    = 1;
    localparam int         ADB_BANK_CS_BIT = 4;
    localparam logic [7:0] ADB_SLEEP_RST   = 8'h00;
    localparam logic [7:0] ADB_BOOT_RST    = 8'h02;
    localparam logic [7:0] ADB_BANK_RST    = 8'h00;
    localparam int         ADB_EV_ADDR     = 0;
    localparam int         ADB_EV_OPC      = 1;

    // ------------------------------------------------------------------
    // Address map
    // ------------------------------------------------------------------
    localparam logic [15:0] ADB_CORE_END   = 16'h001f;
    localparam logic [15:0] ADB_PERI_END   = 16'h007f;
    localparam logic [15:0] ADB_RAM_END    = 16'h17ff;
    localparam logic [15:0] ADB_BANK_LO    = 16'h8000;
    localparam logic [15:0] ADB_BANK_HI    = 16'hbfff;
    localparam logic [15:0] ADB_BOOT_LO    = 16'hfe00;
    localparam logic [15:0] ADB_SLEEP_ADDR = 16'hffff;
    localparam logic [15:0] ADB_EXT_START  = 16'h1800;
    localparam logic [1:0]  ADB_ROOT_PAGE  = 2'h3;

    // ------------------------------------------------------------------
    // Strobe timing
    // ------------------------------------------------------------------
    localparam int         ADB_CLK_NS    = 5;
    localparam int         ADB_SETUP_NS  = 10;
    localparam int         ADB_STROBE_NS = 40;
    localparam logic [3:0] ADB_SETUP_CYC =
        4'((ADB_SETUP_NS + ADB_CLK_NS - 1) / ADB_CLK_NS);
    localparam logic [3:0] ADB_STROBE_CYC =
        4'((ADB_STROBE_NS + ADB_CLK_NS - 1) / ADB_CLK_NS);

    typedef enum logic [2:0] {
        ADB_REG_CORE,
        ADB_REG_PERI,
        ADB_RAM,
        ADB_ROM_ROOT,
        ADB_ROM_BANK,
        ADB_ROM_BOOT
    } adb_region_e;

    typedef enum logic [1:0] {
        ADB_IDLE,
        ADB_SETUP,
        ADB_STROBE
    } adb_state_e;

    function automatic adb_region_e adb_decode(input logic [15:0] a,
                                               input logic        boot);
        if (a <= ADB_CORE_END) begin
            return ADB_REG_CORE;
        end else if (a <= ADB_PERI_END) begin
            return ADB_REG_PERI;
        end else if (a <= ADB_RAM_END) begin
            return ADB_RAM;
        end else if (a >= ADB_BANK_LO && a <= ADB_BANK_HI) begin
            return ADB_ROM_BANK;
        end else if (a >= ADB_BOOT_LO && boot) begin
            return ADB_ROM_BOOT;
        end else begin
            return ADB_ROM_ROOT;
        end
    endfunction

endpackage

// File: core/adb_sync.sv
`timescale 1ns/10ps
`default_nettype none
module adb_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // Data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_reg <= '0;
            q        <= '0;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule
`default_nettype wire

// File: core/adb_top.sv
// Decided for this implementation: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module adb_top
    import adb_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Processor side
    input  wire logic [15:0] cpu_addr,
    input  wire logic [7:0]  cpu_wdata,
    input  wire logic        cpu_req,
    input  wire logic        cpu_rnw,
    input  wire logic        cpu_fetch,
    input  wire logic        cpu_opcode_bad,
    output logic      [7:0]  cpu_rdata,
    output logic             cpu_ready,
    output logic             cpu_trap,
    output logic      [15:0] reset_vector,
    // Internal bus produced for on-chip functions
    output logic      [15:0] int_addr,
    output logic      [7:0]  int_wdata,
    output logic             int_rnw,
    output logic             int_core_sel,
    output logic             int_peri_sel,
    output logic             int_ram_sel,
    output logic             int_boot_sel,
    input  wire logic [7:0]  int_rdata,
    // Register port
    input  wire logic [2:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    output logic             irq,
    // Emulation pins
    input  wire logic        emulation_select,
    input  wire logic        address_strobe_in,
    input  wire logic [15:14] emu_addr_hi,
    // External memory pins
    output logic      [7:0]  addr_lo_o,
    input  wire logic [13:8] addr_mid_i,
    output logic      [13:8] addr_mid_o,
    output logic             addr_mid_oe_n,
    output logic      [17:14] bank_addr,
    input  wire logic [7:0]  data_i,
    output logic      [7:0]  data_o,
    output logic             data_oe_n,
    input  wire logic        rnw_i,
    output logic             rnw_o,
    output logic             rnw_oe_n,
    output logic             program_chip_select_n,
    output logic             second_chip_select_n,
    output logic             output_enable_n,
    output logic             write_enable_n
);
    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [7:0]  data_s;
    logic [13:8] mid_s;
    logic [1:0]  hi_s;
    logic        emu_s;
    logic        as_s;
    logic        rnw_s;

    // Pins pass two flops before any logic.
    adb_sync #(.W(19)) u_sync (
        .clk (clk),
        .rst (rst),
        .d   ({data_i, addr_mid_i, emu_addr_hi, emulation_select,
               address_strobe_in, rnw_i}),
        .q   ({data_s, mid_s, hi_s, emu_s, as_s, rnw_s})
    );

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [7:0] sleep_port_reg;
    logic [7:0] boot_port_reg;
    logic [7:0] bank_reg;
    logic [1:0] status_reg;
    logic [1:0] enable_reg;
    logic       boot_rom_select;
    logic       sleep_sel;

    assign boot_rom_select = boot_port_reg[ADB_BOOT_BIT];
    assign sleep_sel       = sleep_port_reg[ADB_SLEEP_BIT];

    // The bank register is write only.
    // It picks the page and select of banked accesses.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sleep_port_reg <= ADB_SLEEP_RST;
            boot_port_reg  <= ADB_BOOT_RST;
            bank_reg       <= ADB_BANK_RST;
        end else if (reg_wr) begin
            if (reg_addr == ADB_OFS_SLEEP) begin
                sleep_port_reg <= reg_wdata;
            end else if (reg_addr == ADB_OFS_BOOT) begin
                boot_port_reg <= reg_wdata;
            end else if (reg_addr == ADB_OFS_BANK) begin
                bank_reg <= reg_wdata;
            end
        end
    end

    // Enable bits share the status layout.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            enable_reg <= 2'h0;
        end else if (reg_wr && reg_addr == ADB_OFS_ENABLE) begin
            enable_reg <= reg_wdata[1:0];
        end
    end

    // ------------------------------------------------------------------
    // Emulation bus selection
    // ------------------------------------------------------------------
    // The low address byte latch follows the data pins while the strobe
    // is high and holds once it falls, like the transparent latch of a
    // multiplexed bus, but built from a flip-flop on the single clock.
    logic [7:0]  emu_lo_reg;
    logic [15:0] bus_addr;
    logic        bus_req;
    logic        bus_rnw;
    logic [7:0]  bus_wdata;
    logic        as_d_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            emu_lo_reg <= 8'h00;
            as_d_reg   <= 1'b0;
        end else begin
            as_d_reg <= as_s;
            if (as_s) begin
                emu_lo_reg <= data_s;
            end
        end
    end

    // In emulation the pins drive every bus.
    always_comb begin
        if (emu_s) begin
            bus_addr  = {hi_s, mid_s, emu_lo_reg};
            bus_rnw   = rnw_s;
            bus_wdata = data_s;
            bus_req   = as_d_reg && !as_s;
        end else begin
            bus_addr  = cpu_addr;
            bus_rnw   = cpu_rnw;
            bus_wdata = cpu_wdata;
            bus_req   = cpu_req;
        end
    end

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    adb_region_e region;
    logic        is_ext;
    logic        use_second;

    assign region     = adb_decode(bus_addr, boot_rom_select);
    assign is_ext     = region == ADB_ROM_ROOT || region == ADB_ROM_BANK;
    assign use_second = region == ADB_ROM_BANK
                        && bank_reg[ADB_BANK_CS_BIT];

    assign int_addr     = bus_addr;
    assign int_wdata    = bus_wdata;
    assign int_rnw      = bus_rnw;
    assign int_core_sel = bus_req && region == ADB_REG_CORE;
    assign int_peri_sel = bus_req && region == ADB_REG_PERI;
    assign int_ram_sel  = bus_req && region == ADB_RAM;
    assign int_boot_sel = bus_req && region == ADB_ROM_BOOT;

    // Reset vectors into the boot ROM while the boot bit is 1; the boot code later jumps
    // to the external start address, which is the vector once the bit is 0.
    assign reset_vector = boot_rom_select ? ADB_SLEEP_ADDR - 16'h0001
                                          : ADB_EXT_START;

    // ------------------------------------------------------------------
    // External cycle sequencer
    // ------------------------------------------------------------------
    adb_state_e state_reg;
    logic [3:0] cnt_reg;
    logic       cyc_rnw_reg;
    logic       cyc_pcs_reg;
    logic       cyc_cs2_reg;
    logic [7:0] rd_data_reg;
    logic       done_reg;

    // Ready's own edge must not start a new cycle.
    // A sleeping processor parks on the top address.
    // Sleep leaves the select off, not the cycle.
    // Root pages sit at the top of the external space.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg   <= ADB_IDLE;
            cnt_reg     <= 4'h0;
            cyc_rnw_reg <= 1'b1;
            cyc_pcs_reg <= 1'b0;
            cyc_cs2_reg <= 1'b0;
            addr_lo_o   <= 8'h00;
            addr_mid_o  <= 6'h00;
            bank_addr   <= 4'h0;
            data_o      <= 8'h00;
            rd_data_reg <= 8'h00;
            done_reg    <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            case (state_reg)
                ADB_IDLE: begin
                    if (bus_req && is_ext && !done_reg) begin
                        state_reg   <= ADB_SETUP;
                        cnt_reg     <= ADB_SETUP_CYC;
                        cyc_rnw_reg <= bus_rnw;
                        cyc_cs2_reg <= use_second;
                        cyc_pcs_reg <= !use_second
                            && !(sleep_sel
                                 && bus_addr == ADB_SLEEP_ADDR);
                        addr_lo_o   <= bus_addr[7:0];
                        addr_mid_o  <= bus_addr[13:8];
                        data_o      <= bus_wdata;
                        if (region == ADB_ROM_BANK) begin
                            bank_addr <= bank_reg[3:0];
                        end else begin
                            bank_addr <= {ADB_ROOT_PAGE, bus_addr[15:14]};
                        end
                    end
                end
                ADB_SETUP: begin
                    if (cnt_reg == 4'h1) begin
                        state_reg <= ADB_STROBE;
                        cnt_reg   <= ADB_STROBE_CYC;
                    end else begin
                        cnt_reg <= cnt_reg - 4'h1;
                    end
                end
                ADB_STROBE: begin
                    if (cnt_reg == 4'h1) begin
                        state_reg   <= ADB_IDLE;
                        rd_data_reg <= data_s;
                        done_reg    <= 1'b1;
                        cyc_pcs_reg <= 1'b0;
                        cyc_cs2_reg <= 1'b0;
                        cyc_rnw_reg <= 1'b1;
                    end else begin
                        cnt_reg <= cnt_reg - 4'h1;
                    end
                end
                default: begin
                    state_reg <= ADB_IDLE;
                end
            endcase
        end
    end

    // Strobes only during the strobe phase of an external cycle.
    assign output_enable_n = !(state_reg == ADB_STROBE
                               && cyc_rnw_reg);
    assign write_enable_n  = !(state_reg == ADB_STROBE
                               && !cyc_rnw_reg);
    assign program_chip_select_n = !(state_reg != ADB_IDLE
                                     && cyc_pcs_reg);
    assign second_chip_select_n  = !(state_reg != ADB_IDLE
                                     && cyc_cs2_reg);

    // Output enables are active low: low means this block drives the pin.
    assign data_oe_n     = emu_s || cyc_rnw_reg
                           || state_reg == ADB_IDLE;
    assign addr_mid_oe_n = emu_s;
    assign rnw_oe_n      = emu_s;
    assign rnw_o         = cyc_rnw_reg;

    // Internal regions answer at once.
    // External ones wait out the strobe.
    assign cpu_ready = is_ext ? done_reg : 1'b1;
    assign cpu_rdata = is_ext ? rd_data_reg : int_rdata;

    // ------------------------------------------------------------------
    // Error detection and trap
    // ------------------------------------------------------------------
    // Errors go to the trap and to the status bits, which raise the interrupt line when enabled.
    // Only fetches outside emulation are checked.
    logic [1:0] ev;

    assign ev[ADB_EV_ADDR] = bus_req && cpu_fetch && !emu_s
                             && bus_addr <= ADB_PERI_END;
    assign ev[ADB_EV_OPC]  = bus_req && cpu_fetch && !emu_s
                             && cpu_opcode_bad;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cpu_trap <= 1'b0;
        end else begin
            cpu_trap <= |ev;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            status_reg <= 2'h0;
        end else begin
            // A new event wins over a clear in the same cycle.
            if (reg_wr && reg_addr == ADB_OFS_CLEAR) begin
                status_reg <= (status_reg & ~reg_wdata[1:0]) | ev;
            end else begin
                status_reg <= status_reg | ev;
            end
        end
    end

    // High while any enabled status bit is set.
    assign irq = |(status_reg & enable_reg);

    // ------------------------------------------------------------------
    // Register read
    // ------------------------------------------------------------------
    // Read data stand one cycle, then zero.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            if (reg_addr == ADB_OFS_SLEEP) begin
                reg_rdata <= sleep_port_reg;
            end else if (reg_addr == ADB_OFS_BOOT) begin
                reg_rdata <= boot_port_reg;
            end else if (reg_addr == ADB_OFS_STATUS) begin
                reg_rdata <= {6'h00, status_reg};
            end else if (reg_addr == ADB_OFS_ENABLE) begin
                reg_rdata <= {6'h00, enable_reg};
            end else begin
                reg_rdata <= 8'h00;
            end
        end else begin
            reg_rdata <= 8'h00;
        end
    end
endmodule
`default_nettype wire

// File: tb/adb_props.sv
`timescale 1ns/10ps
`default_nettype none
module adb_props (
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst,
    // Processor side
    input wire logic [15:0] cpu_addr,
    input wire logic        cpu_req,
    input wire logic        cpu_fetch,
    input wire logic        cpu_opcode_bad,
    input wire logic        cpu_ready,
    input wire logic        cpu_trap,
    input wire logic [15:0] reset_vector,
    input wire logic        int_core_sel,
    input wire logic        int_peri_sel,
    input wire logic        int_ram_sel,
    input wire logic        int_boot_sel,
    // Pins
    input wire logic        emulation_select,
    input wire logic        addr_mid_oe_n,
    input wire logic        rnw_oe_n,
    input wire logic        data_oe_n,
    input wire logic        program_chip_select_n,
    input wire logic        second_chip_select_n,
    input wire logic        output_enable_n,
    input wire logic        write_enable_n
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    cs_exclusive_a: assert property (
        program_chip_select_n || second_chip_select_n)
        else $error("both chip selects low");
    strobe_exclusive_a: assert property (
        output_enable_n || write_enable_n)
        else $error("read and write strobes low together");
    cs_then_strobe_a: assert property (
        $fell(program_chip_select_n) || $fell(second_chip_select_n)
        |-> ##2 (!output_enable_n || !write_enable_n))
        else $error("strobe not two cycles after select");
    ext_cycle_len_a: assert property (
        $fell(program_chip_select_n) |-> (!program_chip_select_n)[*8]
        ##1 !program_chip_select_n ##1 !program_chip_select_n ##1 cpu_ready)
        else $error("external cycle length wrong");
    internal_no_cs_a: assert property (
        (int_core_sel || int_peri_sel || int_ram_sel || int_boot_sel)
        |-> program_chip_select_n && second_chip_select_n)
        else $error("chip select on internal access");
    ram_map_a: assert property (
        cpu_req && !emulation_select && cpu_addr >= 16'h0080
        && cpu_addr <= 16'h17ff |-> int_ram_sel && !int_boot_sel)
        else $error("ram window not selected");
    boot_map_a: assert property (
        int_boot_sel |-> cpu_addr >= 16'hfe00 && reset_vector == 16'hfffe)
        else $error("boot select outside top window");
    trap_cause_a: assert property (
        cpu_trap |-> $past(cpu_req && cpu_fetch
        && (cpu_addr <= 16'h007f || cpu_opcode_bad)))
        else $error("trap without illegal fetch");
    trap_follow_a: assert property (
        cpu_req && cpu_fetch && !emulation_select && cpu_addr <= 16'h007f
        |=> cpu_trap)
        else $error("illegal fetch gave no trap");
    emu_dir_a: assert property (
        $rose(emulation_select) |-> ##[1:4] (addr_mid_oe_n && rnw_oe_n))
        else $error("pins still driven in emulation");
    data_dir_a: assert property (
        addr_mid_oe_n |-> data_oe_n)
        else $error("data pins driven in emulation");

    cover property ($fell(output_enable_n));
    cover property ($fell(write_enable_n));
    cover property (!second_chip_select_n);
    cover property (cpu_trap);
endmodule

bind adb_top adb_props i_adb_props (.*);
`default_nettype wire

// File: tb/adb_ext_mem.sv
`timescale 1ns/10ps
`default_nettype none
module adb_ext_mem (
    // Clock
    input  wire logic       clk,
    // Memory control pins
    input  wire logic       program_chip_select_n,
    input  wire logic       second_chip_select_n,
    input  wire logic       output_enable_n,
    input  wire logic       write_enable_n,
    // Address and data
    input  wire logic [7:0] addr_lo_o,
    input  wire logic [7:0] data_o,
    output logic      [7:0] data_i
);
    logic [7:0] mem [256];
    logic [7:0] last = 8'h00;
    logic       sel;

    assign sel = !program_chip_select_n || !second_chip_select_n;
    initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'ha5;
    always @(posedge clk) begin
        if (sel && !write_enable_n) mem[addr_lo_o] <= data_o;
        if (sel && !output_enable_n) last <= mem[addr_lo_o];
    end
    // A released bus shows the inverse of the last byte, so stale data fails.
    assign data_i = (sel && !output_enable_n) ? mem[addr_lo_o] : ~last;
endmodule
`default_nettype wire

// File: tb/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic clk = 0, rst = 1, cpu_req = 0, cpu_rnw = 1, cpu_fetch = 0;
    logic cpu_opcode_bad = 0, reg_wr = 0, reg_rd = 0, emulation_select = 0;
    logic address_strobe_in = 0, rnw_i = 0, cpu_ready, cpu_trap, int_rnw;
    logic int_core_sel, int_peri_sel, int_ram_sel, int_boot_sel, irq;
    logic addr_mid_oe_n, data_oe_n, rnw_o, rnw_oe_n, output_enable_n;
    logic program_chip_select_n, second_chip_select_n, write_enable_n;
    logic [15:0] cpu_addr = 0, reset_vector, int_addr;
    logic [7:0] cpu_wdata = 0, int_rdata = 8'h5a, reg_wdata = 0, cpu_rdata;
    logic [7:0] int_wdata, reg_rdata, addr_lo_o, data_i, data_o, rd, r;
    logic [7:0] seen = 0;
    logic [2:0] reg_addr = 0;
    logic [15:14] emu_addr_hi = 0;
    logic [13:8] addr_mid_i = 0, addr_mid_o;
    logic [17:14] bank_addr;
    logic [3:0] bank_seen = 0;
    logic trap_seen = 0;
    int err_total = 0, samples_checked = 0, cycles = 0;

    adb_top i_adb_top (.*);
    adb_ext_mem i_adb_ext_mem (.*);

    always #2.5 clk = ~clk;

    // ------------------------------------------------------------------
    // Monitor and shared tasks
    // ------------------------------------------------------------------
    always @(posedge clk) begin
        seen <= seen | {int_boot_sel, int_ram_sel, int_peri_sel, int_core_sel,
            !write_enable_n, !output_enable_n, !second_chip_select_n,
            !program_chip_select_n};
        if (!program_chip_select_n || !second_chip_select_n) bank_seen <= bank_addr;
        if (cpu_trap === 1'b1) trap_seen <= 1'b1;
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_total++;
            report_and_stop();
        end
    end

    task automatic chk(string nm, logic [15:0] s, logic [15:0] e);
        samples_checked++;
        if (s !== e) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic wreg(logic [2:0] a, logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    task automatic rchk(string nm, logic [2:0] a, logic [7:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(nm, reg_rdata, e);
    endtask

    task automatic acc(logic [15:0] a, logic rnw, logic f, logic b,
                       logic [7:0] d);
        int n;
        n = 0;
        @(negedge clk);
        seen = 8'h00;
        @(posedge clk);
        cpu_addr <= a;
        cpu_rnw <= rnw;
        cpu_fetch <= f;
        cpu_opcode_bad <= b;
        cpu_wdata <= d;
        cpu_req <= 1'b1;
        @(negedge clk);
        while (cpu_ready !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        chk("ready", cpu_ready, 1'b1);
        rd = cpu_rdata;
        @(posedge clk);
        cpu_req <= 1'b0;
        cpu_fetch <= 1'b0;
        cpu_opcode_bad <= 1'b0;
        #1;
    endtask

    task automatic t_acc(string nm, logic [15:0] a, logic rnw, logic [7:0] d,
                         logic [7:0] es, logic [3:0] eb);
        acc(a, rnw, 1'b0, 1'b0, d);
        if (rnw) chk(nm, rd, d);
        chk(nm, seen, es);
        if (es[1:0] != 2'b00) chk(nm, bank_seen, eb);
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        rchk("boot port", 3'h1, 8'h02);
        rchk("sleep port", 3'h0, 8'h00);
        rchk("unmapped", 3'h7, 8'h00);
        chk("vector", reset_vector, 16'hfffe);
        $display("test reset done");
        t_acc("core", 16'h001f, 1, 8'h5a, 8'h10, 0);
        t_acc("peri", 16'h007f, 1, 8'h5a, 8'h20, 0);
        t_acc("ram lo", 16'h0080, 1, 8'h5a, 8'h40, 0);
        t_acc("ram hi", 16'h17ff, 1, 8'h5a, 8'h40, 0);
        t_acc("boot", 16'hfe00, 1, 8'h5a, 8'h80, 0);
        $display("test internal done");
        t_acc("root", 16'h1800, 1, 8'ha5, 8'h05, 4'hc);
        t_acc("root top", 16'hfdff, 1, 8'h5a, 8'h05, 4'hf);
        t_acc("write", 16'h2044, 0, 8'h3c, 8'h09, 4'hc);
        t_acc("readback", 16'h7f44, 1, 8'h3c, 8'h05, 4'hd);
        wreg(3'h2, 8'h15);
        t_acc("bank cs2", 16'h8022, 1, 8'h87, 8'h06, 4'h5);
        wreg(3'h2, 8'h03);
        t_acc("bank csp", 16'hbf01, 1, 8'ha4, 8'h05, 4'h3);
        rchk("bank wo", 3'h2, 8'h00);
        $display("test external done");
        wreg(3'h1, 8'h00);
        chk("vector off", reset_vector, 16'h1800);
        rchk("boot off", 3'h1, 8'h00);
        t_acc("boot ext", 16'hfe10, 1, 8'hb5, 8'h05, 4'hf);
        wreg(3'h0, 8'h02);
        acc(16'hffff, 1'b1, 1'b0, 1'b0, 8'h00);
        chk("sleep cs", seen[1:0], 2'b00);
        t_acc("sleep fffe", 16'hfffe, 1, 8'h5b, 8'h05, 4'hf);
        wreg(3'h0, 8'h00);
        t_acc("awake", 16'hffff, 1, 8'h5a, 8'h05, 4'hf);
        $display("test boot and sleep done");
        wreg(3'h5, 8'h03);
        trap_seen = 1'b0;
        acc(16'h007f, 1'b1, 1'b1, 1'b0, 8'h00);
        repeat (2) @(posedge clk);
        chk("trap addr", trap_seen, 1'b1);
        rchk("status a", 3'h3, 8'h01);
        chk("irq on", irq, 1'b1);
        trap_seen = 1'b0;
        acc(16'h0080, 1'b1, 1'b1, 1'b0, 8'h00);
        repeat (2) @(posedge clk);
        chk("no trap", trap_seen, 1'b0);
        acc(16'h0100, 1'b1, 1'b1, 1'b1, 8'h00);
        rchk("status b", 3'h3, 8'h03);
        wreg(3'h4, 8'h01);
        rchk("clear a", 3'h3, 8'h02);
        wreg(3'h5, 8'h00);
        chk("masked", irq, 1'b0);
        wreg(3'h4, 8'h02);
        rchk("clear b", 3'h3, 8'h00);
        $display("test trap done");
        @(posedge clk);
        emulation_select <= 1'b1;
        repeat (5) @(posedge clk);
        #1;
        chk("emu dir", {addr_mid_oe_n, rnw_oe_n, data_oe_n}, 3'b111);
        seen = 8'h00;
        @(posedge clk);
        addr_mid_i <= 6'h10;
        address_strobe_in <= 1'b1;
        repeat (4) @(posedge clk);
        address_strobe_in <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
        chk("emu addr", int_addr, 16'h10a5);
        chk("emu ram", seen[6], 1'b1);
        chk("emu data", int_wdata, 8'ha5);
        @(posedge clk);
        emulation_select <= 1'b0;
        repeat (5) @(posedge clk);
        #1;
        chk("norm dir", {addr_mid_oe_n, rnw_oe_n, data_oe_n}, 3'b001);
        $display("test emulation done");
        report_and_stop();
    end
endmodule
`default_nettype wire
